// ---- host_regs_pkg.sv ----
// Purpose: Shared constants and types for the host control and status registers
// Assumes: Byte-indexed register port, 10 MHz system clock
// Notes:   Offsets are byte register indices
package host_regs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_COMMAND      = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS   = 8'h03;
  localparam logic [7:0] OFF_IRQ_GATE     = 8'h04;
  localparam logic [7:0] OFF_CREATOR      = 8'h05;
  localparam logic [7:0] OFF_CLK_LOCK     = 8'h06;
  localparam logic [7:0] OFF_SWAP_CFG     = 8'h0f;
  localparam logic [7:0] OFF_LANE_EN_LO   = 8'h10;
  localparam logic [7:0] OFF_LANE_EN_HI   = 8'h11;
  localparam logic [7:0] OFF_EVT_STATUS   = 8'h20;
  localparam logic [7:0] OFF_EVT_ENABLE   = 8'h21;
  localparam logic [7:0] OFF_EVT_CLEAR    = 8'h22;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  localparam int unsigned N_STAT        = 4;
  localparam int unsigned N_LANES       = 6;
  localparam int unsigned CMD_EN_LSB    = 4;
  localparam int unsigned GATE_BIT      = 4;
  localparam int unsigned HSWAP_BIT     = 3;
  localparam int unsigned BYTE_PAIR_SWAP_BIT     = 0;
  localparam logic [7:0]  CMD_WMASK     = 8'hf0;
  localparam logic [7:0]  GATE_WMASK    = 8'h10;
  localparam logic [7:0]  SWAP_WMASK    = 8'h09;
  localparam logic [7:0]  LANE_WMASK    = 8'h3f;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [7:0]  EVT_WMASK     = 8'h0f;
  // Arbitrary neutral creator code
  localparam logic [7:0]  CREATOR_CODE  = 8'h5a;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_HZ       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;
  // Half period of the test level, one rising edge per tick period
  localparam int unsigned TICK_TOGGLE   = TICK_CYCLES / 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [2:0] tx;
    logic [2:0] rx;
  } lane_en_s;

endpackage

// ---- word_swapper.sv ----
// Purpose: Halfword and byte-pair swapping of a 32-bit data word
// Assumes: Swap selects are stable register bits
// Notes:   Output is registered
`timescale 1ns/1ns
module word_swapper (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Controls
  input  wire logic        i_halfword_swap,
  input  wire logic        i_byte_pair_swap,
  // Data
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data
);

  wire logic [31:0] half_w;
  wire logic [31:0] byte_w;

  assign half_w = i_halfword_swap ? {i_data[15:0], i_data[31:16]} : i_data;      // see RQ10
  assign byte_w = i_byte_pair_swap ?
                  {half_w[23:16], half_w[31:24], half_w[7:0], half_w[15:8]} :
                  half_w;                                                        // see RQ11 RQ12

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= 32'h0000_0000;
    end else begin
      o_data <= byte_w;
    end
  end

  a_full_reverse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ12
    (i_halfword_swap && i_byte_pair_swap) |=>
      o_data == {$past(i_data[7:0]), $past(i_data[15:8]),
                 $past(i_data[23:16]), $past(i_data[31:24])})
    else $error("Full byte reversal wrong");

endmodule

// ---- host_ctrl_status_regs.sv ----
// Purpose: Host control and status register group with interrupts and lane enables
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Status inputs and lock flags are asynchronous and synchronised
`timescale 1ns/1ns

// Summary of operation
// RQ1 - Status irq bits 7-4 assert only when their command enable bit is set
// RQ2 - Enabled status input going high raises the host interrupt
// RQ3 - Pending status irq clears when its enable is disabled then re-enabled
// RQ4 - Status bits 3-0 read sampled user inputs; register is read-only (bits 2-0 read the user inputs, bit 3 the test event)
// RQ5 - A once-per-second test event drives the status interrupt path
// RQ6 - Gate bit 4 masks all status irqs without altering per-bit enables (enabled event status bits still raise the host irq while the gate is clear)
// RQ7 - Read-only creator code register identifies the loaded image creator
// RQ8 - Clock status bit 1 shows transfer clock lock
// RQ9 - Clock status bit 0 shows reference clock lock
// RQ10 - Halfword swap bit 3 exchanges the two 16-bit halves
// RQ11 - Byte swap bit 0 gives byte order 1,0,3,2
// RQ12 - Both swaps give full byte reversal 3,2,1,0
// RQ13 - Lane enable bits 5-0: set enables, clear holds channel in reset
// RQ14 - Bits 5,4,3 enable transmit for ports 2,1,0
// RQ15 - Bits 2,1 enable receive for ports 2,1
// RQ16 - Bit 0 enables receive for port 0
// RQ17 - Command bits 7-4 are the per-bit status irq enables
// RQ18 - Reserved bits read zero and ignore writes
module host_ctrl_status_regs
  import host_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  // User status and clock lock inputs
  input  wire logic [2:0]  i_user_status_inputs,
  input  wire logic        i_reference_clock_locked,
  input  wire logic        i_transfer_clock_locked,
  // Data path
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data,
  // Lane enables and interrupt
  output logic      [5:0]  o_dma_lane_enables,
  output logic             o_host_irq
);

  // ****************************************************************
  // Request decode
  // ****************************************************************
  reg_req_s req;
  assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};

  function automatic logic hit(input reg_req_s r, input logic [7:0] off);
    return r.wr && (r.addr == off);
  endfunction

  wire logic wr_cmd;
  wire logic wr_gate;
  wire logic wr_swap;
  wire logic wr_lane;
  wire logic wr_eena;
  wire logic wr_eclr;
  assign wr_cmd  = hit(req, OFF_COMMAND);
  assign wr_gate = hit(req, OFF_IRQ_GATE);
  assign wr_swap = hit(req, OFF_SWAP_CFG);
  assign wr_lane = hit(req, OFF_LANE_EN_LO);
  assign wr_eena = hit(req, OFF_EVT_ENABLE);
  assign wr_eclr = hit(req, OFF_EVT_CLEAR);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {i_transfer_clock_locked, i_reference_clock_locked, i_user_status_inputs};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************************************
  // One second test tick
  // ****************************************************************
  logic [23:0] tick_cnt_q;
  logic        tick_lvl_q;
  wire  logic  tick_w;
  assign tick_w = (tick_cnt_q == 24'(TICK_TOGGLE - 1));
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 24'h00_0000;
      tick_lvl_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_w ? 24'h00_0000 : tick_cnt_q + 24'h00_0001;
      if (tick_w) begin
        tick_lvl_q <= ~tick_lvl_q;                                               // see RQ5
      end
    end
  end

  // Status bit 3 carries the test event, bits 2-0 the user inputs
  wire logic [3:0] stat_w;
  assign stat_w = {tick_lvl_q, sync2_q[2:0]};                                    // see RQ5

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [3:0] irq_en_q;
  logic       gate_q;
  logic       hswap_q;
  logic       byte_pair_swap_q;
  logic [5:0] lane_q;
  logic [3:0] stat_q;
  logic [3:0] stat_prev_q;
  logic [3:0] irq_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= 4'h0;
      gate_q   <= 1'b0;
      hswap_q  <= 1'b0;
      byte_pair_swap_q  <= 1'b0;
      lane_q   <= 6'h00;
    end else begin
      if (wr_cmd) begin
        irq_en_q <= req.wdata[CMD_EN_LSB +: N_STAT];                             // see RQ17
      end
      if (wr_gate) begin
        gate_q <= req.wdata[GATE_BIT];                                           // see RQ6
      end
      if (wr_swap) begin
        hswap_q <= req.wdata[HSWAP_BIT];
        byte_pair_swap_q <= req.wdata[BYTE_PAIR_SWAP_BIT];
      end
      if (wr_lane) begin
        lane_q <= req.wdata[N_LANES-1:0];                                        // see RQ13
      end
    end
  end

  // ****************************************************************
  // Status interrupt bits
  // ****************************************************************
  wire logic [3:0] rise_w;
  wire logic [3:0] disarm_w;
  wire logic [3:0] irq_d;
  assign rise_w   = stat_w & ~stat_prev_q;
  assign disarm_w = wr_cmd ? ~req.wdata[CMD_EN_LSB +: N_STAT] : 4'h0;
  // Latch on rising enabled input; disable clears; set wins only while enabled
  assign irq_d    = ((irq_q & ~disarm_w) | (rise_w & irq_en_q & ~disarm_w));     // see RQ1

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_q      <= 4'h0;
      stat_prev_q <= 4'h0;
      irq_q       <= 4'h0;
    end else begin
      stat_q      <= stat_w;                                                     // see RQ4
      stat_prev_q <= stat_w;
      irq_q       <= irq_d;                                                      // see RQ3
    end
  end

  // ****************************************************************
  // Event status, enable and clear
  // ****************************************************************
  logic [3:0] evt_q;
  logic [3:0] evt_en_q;
  wire  logic [3:0] evt_set_w;
  wire  logic [3:0] evt_clr_w;
  assign evt_set_w = irq_d & ~irq_q;
  assign evt_clr_w = wr_eclr ? req.wdata[N_STAT-1:0] : 4'h0;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_q    <= 4'h0;
      evt_en_q <= 4'h0;
    end else begin
      evt_q <= (evt_q & ~evt_clr_w) | evt_set_w;
      if (wr_eena) begin
        evt_en_q <= req.wdata[N_STAT-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  wire logic irq_w;
  assign irq_w = (gate_q && (|irq_q)) || (|(evt_q & evt_en_q));                 // see RQ2

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_irq <= 1'b0;
    end else begin
      o_host_irq <= irq_w;                                                       // see RQ6
    end
  end

  // ****************************************************************
  // Lane enables
  // ****************************************************************
  lane_en_s lanes_w;
  assign lanes_w = '{tx: lane_q[5:3], rx: lane_q[2:0]};                          // see RQ14

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_lane_enables <= 6'h00;
    end else begin
      o_dma_lane_enables <= {lanes_w.tx, lanes_w.rx};                            // see RQ15
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [7:0] rdata_w;
  always_comb begin
    rdata_w = RST_BYTE;
    unique case (req.addr)
      OFF_COMMAND:    rdata_w = {irq_en_q, 4'h0} & CMD_WMASK;
      OFF_IRQ_STATUS: rdata_w = {irq_q, stat_q};                                 // see RQ4
      OFF_IRQ_GATE:   rdata_w = {3'h0, gate_q, 4'h0} & GATE_WMASK;               // see RQ18
      OFF_CREATOR:    rdata_w = CREATOR_CODE;                                    // see RQ7
      OFF_CLK_LOCK:   rdata_w = {6'h00, sync2_q[4], sync2_q[3]};                 // see RQ8 RQ9
      OFF_SWAP_CFG:   rdata_w = {4'h0, hswap_q, 2'h0, byte_pair_swap_q} & SWAP_WMASK;
      OFF_LANE_EN_LO: rdata_w = {2'h0, lane_q} & LANE_WMASK;                     // see RQ16
      OFF_LANE_EN_HI: rdata_w = RST_BYTE;
      OFF_EVT_STATUS: rdata_w = {4'h0, evt_q} & EVT_WMASK;
      OFF_EVT_ENABLE: rdata_w = {4'h0, evt_en_q} & EVT_WMASK;
      default:        rdata_w = RST_BYTE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= RST_BYTE;
    end else if (req.rd) begin
      o_reg_rdata <= rdata_w;
    end else begin
      o_reg_rdata <= RST_BYTE;
    end
  end

  // ****************************************************************
  // Data path swapping
  // ****************************************************************
  word_swapper u_swap (
    .i_clk_sys        (i_clk_sys),
    .i_rst_n          (i_rst_n),
    .i_halfword_swap  (hswap_q),                                                 // see RQ10
    .i_byte_pair_swap (byte_pair_swap_q),                                                 // see RQ11
    .i_data           (i_data),
    .o_data           (o_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_needs_en: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ1
    $rose(irq_q[0]) |-> $past(irq_en_q[0]))
    else $error("Irq bit set without enable");

  a_irq_raised: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ2
    (gate_q && irq_q[1]) |=> o_host_irq)
    else $error("Enabled irq not raised");

  a_irq_rearm_clr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ3
    (wr_cmd && !req.wdata[CMD_EN_LSB]) |=> !irq_q[0])
    else $error("Disable did not clear irq");

  a_irq_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ3
    (irq_q[2] && !wr_cmd) |=> irq_q[2])
    else $error("Irq cleared without rearm");

  a_status_sample: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ4
    ##1 stat_q[2:0] == $past(sync2_q[2:0]))
    else $error("Status not sampled");

  a_gate_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ6
    (!gate_q && !(|(evt_q & evt_en_q))) |=> !o_host_irq)
    else $error("Gate did not block irq");

  a_gate_keeps_en: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ6
    (wr_gate && !wr_cmd) |=> $stable(irq_en_q))
    else $error("Gate write changed enables");

  a_lock_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ9
    (req.rd && req.addr == OFF_CLK_LOCK) |=> o_reg_rdata[0] == $past(sync2_q[3]))
    else $error("Lock bit wrong");

  a_creator_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ7
    (req.rd && req.addr == OFF_CREATOR) |=> o_reg_rdata == CREATOR_CODE)
    else $error("Creator code wrong");

  a_lane_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ13
    wr_lane |=> ##1 o_dma_lane_enables == $past(req.wdata[5:0], 2))
    else $error("Lane enables wrong");

  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ18
    (req.rd && req.addr == OFF_SWAP_CFG) |=> o_reg_rdata[7:4] == 4'h0)
    else $error("Reserved bits not zero");

  a_xfer_lock_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ8
    (req.rd && req.addr == OFF_CLK_LOCK) |=> o_reg_rdata[1] == $past(sync2_q[4]))
    else $error("Transfer lock bit wrong");

  a_cmd_enables: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ17
    wr_cmd |=> irq_en_q == $past(req.wdata[CMD_EN_LSB +: N_STAT]))
    else $error("Command enables not taken");

  a_tick_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ5
    tick_cnt_q < 24'(TICK_TOGGLE))
    else $error("Test tick counter out of range");

  a_tick_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ5
    1'b1 |=> ($changed(tick_lvl_q) == $past(tick_w)))
    else $error("Test level toggled off its tick");

  a_half_swap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ10
    (hswap_q && !byte_pair_swap_q) |=> o_data == {$past(i_data[15:0]), $past(i_data[31:16])})
    else $error("Halfword swap wrong");

  a_byte_swap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see RQ11
    (!hswap_q && byte_pair_swap_q) |=>
      o_data == {$past(i_data[23:16]), $past(i_data[31:24]),
                 $past(i_data[7:0]), $past(i_data[15:8])})
    else $error("Byte pair swap wrong");

endmodule

// ---- host_bus_model.sv ----
// Purpose: Host computer model that drives the plain register port
// Assumes: One access at a time, strobes one cycle long
// Notes:   Address and data are scrambled while no strobe is high
`timescale 1ns/1ns
module host_bus_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Register port
  input  wire logic [7:0] i_reg_rdata,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd
);
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_addr  <= a;
    o_reg_wdata <= d;
    o_reg_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_reg_wr    <= 1'b0;
    o_reg_addr  <= ~a;
    o_reg_wdata <= ~d;
  endtask

  // Read data is taken in the cycle after the strobe only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_addr <= a;
    o_reg_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_reg_rd   <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_clk_sys);
    d = i_reg_rdata;
  endtask
endmodule

// ---- host_ctrl_status_regs_bench.sv ----
// Purpose: Self-checking bench for the host control and status registers
// Assumes: Fixed register and interrupt latencies
// Notes:   The 1 Hz test source is too slow to exercise here
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module host_ctrl_status_regs_bench;
  import host_regs_pkg::*;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [31:0] din;
    logic [31:0] dout;
  } swap_row_s;

  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [2:0]  user_status;
  logic        ref_lock;
  logic        xfer_lock;
  logic [31:0] data_in;
  logic [31:0] data_out;
  logic [5:0]  lane_en;
  logic        host_irq;
  logic [7:0]  rv;
  logic [7:0]  bm;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [7:0]  ra [8] = '{OFF_COMMAND, OFF_IRQ_GATE, OFF_SWAP_CFG, OFF_LANE_EN_LO,
                          OFF_LANE_EN_HI, OFF_IRQ_STATUS, OFF_CREATOR, 8'h30};
  logic [7:0]  rm [8] = '{8'hf0, 8'h10, 8'h09, 8'h3f, 8'h00, 8'h00, CREATOR_CODE, 8'h00};
  swap_row_s   rows [4] = '{'{8'h00, 32'h1122_3344, 32'h1122_3344},
                            '{8'h08, 32'h1122_3344, 32'h3344_1122},
                            '{8'h01, 32'h1122_3344, 32'h2211_4433},
                            '{8'h09, 32'h1122_3344, 32'h4433_2211}};

  always #50 clk_sys = ~clk_sys;

  host_ctrl_status_regs i_dut (
    .i_clk_sys                (clk_sys),
    .i_rst_n                  (rst_n),
    .i_reg_addr               (reg_addr),
    .i_reg_wdata              (reg_wdata),
    .i_reg_wr                 (reg_wr),
    .i_reg_rd                 (reg_rd),
    .o_reg_rdata              (reg_rdata),
    .i_user_status_inputs     (user_status),
    .i_reference_clock_locked (ref_lock),
    .i_transfer_clock_locked  (xfer_lock),
    .i_data                   (data_in),
    .o_data                   (data_out),
    .o_dma_lane_enables       (lane_en),
    .o_host_irq               (host_irq)
  );

  host_bus_model i_host (
    .i_clk_sys   (clk_sys),
    .i_reg_rdata (reg_rdata),
    .o_reg_addr  (reg_addr),
    .o_reg_wdata (reg_wdata),
    .o_reg_wr    (reg_wr),
    .o_reg_rd    (reg_rd)
  );

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    i_host.rd(a, rv);
    `CHK(nm, exp, rv)
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("[FAIL] run length expected done seen timeout");
    end_sim();
  end

  initial begin
    rst_n       <= 1'b0;
    user_status <= 3'h0;
    ref_lock    <= 1'b0;
    xfer_lock   <= 1'b0;
    data_in     <= 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // ****************************************************************
    // Table rows: data word swapping
    // ****************************************************************
    foreach (rows[i]) begin
      i_host.wr(OFF_SWAP_CFG, rows[i].cfg);
      @(posedge clk_sys);
      data_in <= rows[i].din;
      repeat (3) @(posedge clk_sys);
      `CHK("swapped word", rows[i].dout, data_out)
    end
    // ****************************************************************
    // Reset values, reserved bits and read-only places
    // ****************************************************************
    i_host.wr(OFF_SWAP_CFG, 8'h00);
    foreach (ra[i]) begin
      rchk(ra[i], (i == 6) ? CREATOR_CODE : 8'h00, "reset value");
      i_host.wr(ra[i], 8'hff);
      rchk(ra[i], rm[i], "written value");
      i_host.wr(ra[i], 8'h00);
    end
    @(posedge clk_sys);
    `CHK("idle read data", 8'h00, reg_rdata)
    // ****************************************************************
    // Lane enables, one bit at a time
    // ****************************************************************
    for (int i = 0; i < 6; i++) begin
      bm = 8'h01 << i;
      i_host.wr(OFF_LANE_EN_LO, bm);
      repeat (3) @(posedge clk_sys);
      `CHK("lane enables", bm[5:0], lane_en)
    end
    i_host.wr(OFF_LANE_EN_LO, 8'h00);
    // ****************************************************************
    // Clock lock flags
    // ****************************************************************
    for (int i = 0; i < 4; i++) begin
      bm = 8'(i);
      xfer_lock <= bm[1];
      ref_lock  <= bm[0];
      repeat (4) @(posedge clk_sys);
      rchk(OFF_CLK_LOCK, bm, "lock status");
    end
    // ****************************************************************
    // Status interrupts per user input
    // ****************************************************************
    i_host.wr(OFF_IRQ_GATE, 8'h10);
    for (int i = 0; i < 3; i++) begin
      bm = 8'h01 << i;
      user_status <= bm[2:0];
      repeat (6) @(posedge clk_sys);
      `CHK("irq while disabled", 1'b0, host_irq)
      rchk(OFF_IRQ_STATUS, bm, "status disabled");
      user_status <= 3'h0;
      repeat (4) @(posedge clk_sys);
      i_host.wr(OFF_COMMAND, {bm[3:0], 4'h0});
      user_status <= bm[2:0];
      repeat (6) @(posedge clk_sys);
      `CHK("irq raised", 1'b1, host_irq)
      rchk(OFF_IRQ_STATUS, {bm[3:0], bm[3:0]}, "status enabled");
      i_host.wr(OFF_IRQ_GATE, 8'h00);
      repeat (3) @(posedge clk_sys);
      `CHK("irq gated off", 1'b0, host_irq)
      rchk(OFF_COMMAND, {bm[3:0], 4'h0}, "enables kept");
      i_host.wr(OFF_IRQ_GATE, 8'h10);
      repeat (3) @(posedge clk_sys);
      `CHK("irq gated on", 1'b1, host_irq)
      i_host.wr(OFF_COMMAND, 8'h00);
      i_host.wr(OFF_COMMAND, {bm[3:0], 4'h0});
      repeat (3) @(posedge clk_sys);
      `CHK("irq cleared", 1'b0, host_irq)
      rchk(OFF_IRQ_STATUS, bm, "status cleared");
      user_status <= 3'h0;
      i_host.wr(OFF_COMMAND, 8'h00);
    end
    // ****************************************************************
    // Sticky event status, enable and clear
    // ****************************************************************
    i_host.wr(OFF_IRQ_GATE, 8'h00);
    rchk(OFF_EVT_STATUS, 8'h07, "event status");
    `CHK("event masked", 1'b0, host_irq)
    i_host.wr(OFF_EVT_ENABLE, 8'h02);
    repeat (3) @(posedge clk_sys);
    `CHK("event irq", 1'b1, host_irq)
    rchk(OFF_EVT_ENABLE, 8'h02, "event enable");
    i_host.wr(OFF_EVT_CLEAR, 8'h02);
    repeat (3) @(posedge clk_sys);
    `CHK("event cleared", 1'b0, host_irq)
    rchk(OFF_EVT_STATUS, 8'h05, "event after clear");
    // ****************************************************************
    // Reset in mid-run
    // ****************************************************************
    i_host.wr(OFF_LANE_EN_LO, 8'h3f);
    i_host.wr(OFF_IRQ_GATE, 8'h10);
    repeat (3) @(posedge clk_sys);
    `CHK("lanes before reset", 6'h3f, lane_en)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("lanes in reset", 6'h00, lane_en)
    `CHK("irq in reset", 1'b0, host_irq)
    rst_n <= 1'b1;
    rchk(OFF_IRQ_GATE, 8'h00, "gate after reset");
    rchk(OFF_LANE_EN_LO, 8'h00, "lanes after reset");
    rchk(OFF_EVT_STATUS, 8'h00, "events after reset");
    end_sim();
  end
endmodule
